// >>> i2c_abort_clear.sv
// Operation
// RULE_01: Abort request sends STOP on the bus, then flushes the transmit FIFO.
// RULE_02: Abort request acts only in master mode; ignored in target mode.
// RULE_03: Software stops filling the FIFO and clears DMA before aborting.
// RULE_04: Abort completion raises abort event and records user-request cause.
// RULE_05: Two independent filter counters, one for SCL, one for SDA.
// RULE_06: Counter starts on change; stable until limit updates copy, counter stops.
// RULE_07: Change back before limit resets counter; copy keeps old value.
// RULE_08: Each input passes a two-flop synchroniser before the filter.
// RULE_09: Spike limit is 8 bits, always readable, writable only when disabled.
// RULE_10: Writing a value below one stores one.
// RULE_11: Filtering is identical for rising and falling edges.
// RULE_12: Software picks a limit rejecting 50 ns spikes at its clock.
// RULE_13: Fast-mode-plus needs 32 MHz clock, speed 2'b10, counts programmed first.
// RULE_14: SDA stuck low: at most nine SCL pulses are generated.
// RULE_15: During recovery SDA is released and checked each pulse.
// RULE_16: SDA back high within nine pulses: STOP is generated.
// RULE_17: SDA still low after nine pulses: system applies hardware reset.
// RULE_18: SCL stuck low has no recovery here; system resets the bus.
// RULE_19: SCL filter delay is spike limit plus two clock cycles.
// RULE_20: Recovery outcome, success or failure, is a readable status flag.
//
// Master-side abort, spike filtering and SDA bus clear for an I2C controller.
// Assumes register writes arrive as CLK-domain strobes and that the bus pads
// are open drain: an output enable pulls the line low, released means high.

`timescale 1ns/1ps

module i2c_abort_clear (
    input  wire logic                     CLK,
    input  wire logic                     RESET_N,
    input  wire logic                     LINK_CLK,
    input  wire logic                     ENABLE,
    input  wire logic                     MASTER_MODE,
    input  wire logic                     ABORT_REQ,
    input  wire logic                     ABORT_CAUSE_CLR,
    input  wire logic                     SPKLEN_WR,
    input  wire logic [i2c_ctl_pkg::SPK_W-1:0] SPKLEN_WDATA,
    input  wire logic                     RECOVER_REQ,
    input  wire logic                     SCL_IN,
    input  wire logic                     SDA_IN,
    output logic [i2c_ctl_pkg::SPK_W-1:0] SPKLEN_RDATA,
    output logic                          ABORT_DONE,
    output logic                          ABORT_CAUSE_USER,
    output logic                          TX_FLUSH,
    output logic                          RECOVER_BUSY,
    output logic                          RECOVER_OK,
    output logic                          RECOVER_FAIL,
    output logic                          SCL_FILT,
    output logic                          SDA_FILT,
    output logic                          SCL_OUT,
    output logic                          SCL_OE,
    output logic                          SDA_OUT,
    output logic                          SDA_OE
);
    import i2c_ctl_pkg::*;

    // ------------------------------------------------------------------------
    // Register side (CLK domain)
    // ------------------------------------------------------------------------
    logic [SPK_W-1:0] spk_ff;
    logic             spk_tgl_ff;
    logic             abort_tgl_ff;
    logic             rec_tgl_ff;
    logic             done_s1_ff;
    logic             done_s2_ff;
    logic             done_s3_ff;
    logic             abort_done_ff;
    logic             flush_ff;
    logic             cause_ff;
    logic [2:0]       st_s1_ff;
    logic [2:0]       st_s2_ff;
    // Link-side flags that the register side synchronises
    logic             done_tgl_ff;
    logic             rec_busy_ff;
    logic             rec_ok_ff;
    logic             rec_fail_ff;

    wire              spk_take   = SPKLEN_WR && !ENABLE;                        // [RULE_09]
    wire [SPK_W-1:0]  spk_value  = (SPKLEN_WDATA < SPK_MIN) ? SPK_MIN : SPKLEN_WDATA; // [RULE_10]
    wire              abort_take = ABORT_REQ && MASTER_MODE;                    // [RULE_02]
    wire              done_evt   = done_s2_ff ^ done_s3_ff;

    // Spike limit: held while enabled, readable always
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            spk_ff     <= SPK_RESET;
            spk_tgl_ff <= 1'b0;
        end else if (spk_take) begin
            spk_ff     <= spk_value;    // [RULE_09] [RULE_10]
            spk_tgl_ff <= ~spk_tgl_ff;
        end
    end

    // Requests travel to the link side as toggles
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            abort_tgl_ff <= 1'b0;
            rec_tgl_ff   <= 1'b0;
        end else begin
            abort_tgl_ff <= abort_tgl_ff ^ abort_take;  // [RULE_01] [RULE_02]
            rec_tgl_ff   <= rec_tgl_ff ^ RECOVER_REQ;
        end
    end

    // Completion toggle back from the link side
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
        end else begin
            done_s1_ff <= done_tgl_ff;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
        end
    end

    // Flush follows the STOP; the cause flag is sticky and a new completion
    // in the clearing cycle wins, so no abort goes unreported
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            abort_done_ff <= 1'b0;
            flush_ff      <= 1'b0;
            cause_ff      <= 1'b0;
        end else begin
            abort_done_ff <= done_evt;                              // [RULE_04]
            flush_ff      <= done_evt;                              // [RULE_01]
            cause_ff      <= done_evt | (cause_ff & ~ABORT_CAUSE_CLR); // [RULE_04]
        end
    end

    // Recovery status levels, two flops each
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_s1_ff <= 3'h0;
            st_s2_ff <= 3'h0;
        end else begin
            st_s1_ff <= {rec_busy_ff, rec_ok_ff, rec_fail_ff};
            st_s2_ff <= st_s1_ff;   // [RULE_20]
        end
    end

    assign SPKLEN_RDATA     = spk_ff;
    assign ABORT_DONE       = abort_done_ff;
    assign TX_FLUSH         = flush_ff;
    assign ABORT_CAUSE_USER = cause_ff;
    assign RECOVER_BUSY     = st_s2_ff[2];
    assign RECOVER_OK       = st_s2_ff[1];
    assign RECOVER_FAIL     = st_s2_ff[0];

    // ------------------------------------------------------------------------
    // Link side (LINK_CLK domain)
    // ------------------------------------------------------------------------
    logic [2:0]       ab_s_ff;
    logic [2:0]       rc_s_ff;
    logic [2:0]       sp_s_ff;
    logic [SPK_W-1:0] lspk_ff;
    logic             ab_pend_ff;
    logic             rc_pend_ff;
    logic             is_abort_ff;
    logic [HC_W-1:0]  hc_ff;
    logic [3:0]       pulses_ff;
    logic             scl_oe_ff;
    logic             sda_oe_ff;
    link_state_t      state_ff;
    link_state_t      nxt_state;
    logic             scl_f;
    logic             sda_f;

    wire ab_evt  = ab_s_ff[1] ^ ab_s_ff[2];
    wire rc_evt  = rc_s_ff[1] ^ rc_s_ff[2];
    wire sp_evt  = sp_s_ff[1] ^ sp_s_ff[2];
    wire tick    = hc_ff == HC_W'(HALF_CYC - 1);
    wire last_rc = pulses_ff == RECOVER_PULSES;
    wire idle    = state_ff == L_IDLE;

    // Request toggles synchronised; the second and third flops are compared
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ab_s_ff <= 3'h0;
            rc_s_ff <= 3'h0;
            sp_s_ff <= 3'h0;
            lspk_ff <= SPK_RESET;
        end else begin
            ab_s_ff <= {ab_s_ff[1:0], abort_tgl_ff};
            rc_s_ff <= {rc_s_ff[1:0], rec_tgl_ff};
            sp_s_ff <= {sp_s_ff[1:0], spk_tgl_ff};
            if (sp_evt) begin
                lspk_ff <= spk_ff;  // Stable for many cycles before the toggle lands
            end
        end
    end

    // One filter per line, separate counters; SCL filter delay is limit + 2
    i2c_glitch_filter #(.LIMIT_W(SPK_W)) u_scl_filter (   // [RULE_05] [RULE_19]
        .clk      (LINK_CLK),
        .reset_n  (RESET_N),
        .line_in  (SCL_IN),
        .limit    (lspk_ff),
        .filt_out (scl_f)
    );
    i2c_glitch_filter #(.LIMIT_W(SPK_W)) u_sda_filter (   // [RULE_05]
        .clk      (LINK_CLK),
        .reset_n  (RESET_N),
        .line_in  (SDA_IN),
        .limit    (lspk_ff),
        .filt_out (sda_f)
    );

    // Bus sequencer: STOP for abort or successful clear, pulse train for clear.
    // SCL stuck low is not handled; only a system reset frees that case.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            L_IDLE: begin
                if (ab_pend_ff || ab_evt) begin
                    nxt_state = L_STOP_LOW;     // [RULE_01]
                end else if (rc_pend_ff || rc_evt) begin
                    nxt_state = L_RC_LOW;       // [RULE_14]
                end
            end
            L_STOP_LOW:  if (tick) nxt_state = L_STOP_HIGH;
            L_STOP_HIGH: if (tick) nxt_state = L_STOP_REL;
            L_STOP_REL:  if (tick) nxt_state = L_IDLE;
            L_RC_LOW:    if (tick) nxt_state = L_RC_HIGH;
            L_RC_HIGH: begin
                if (tick) begin
                    if (sda_f) begin
                        nxt_state = L_STOP_LOW;  // [RULE_16]
                    end else if (last_rc) begin
                        nxt_state = L_IDLE;      // [RULE_17]
                    end else begin
                        nxt_state = L_RC_LOW;    // [RULE_15]
                    end
                end
            end
        endcase
    end

    // State, half-period timer and pad enables, all registered
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff  <= L_IDLE;
            hc_ff     <= '0;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            hc_ff     <= (nxt_state != state_ff || tick) ? '0 : hc_ff + 1'b1;
            scl_oe_ff <= (nxt_state == L_STOP_LOW) || (nxt_state == L_RC_LOW);
            sda_oe_ff <= (nxt_state == L_STOP_LOW) || (nxt_state == L_STOP_HIGH); // [RULE_15]
        end
    end

    // Pending requests, pulse count and outcome flags
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ab_pend_ff  <= 1'b0;
            rc_pend_ff  <= 1'b0;
            is_abort_ff <= 1'b0;
            done_tgl_ff <= 1'b0;
            rec_busy_ff <= 1'b0;
            rec_ok_ff   <= 1'b0;
            rec_fail_ff <= 1'b0;
            pulses_ff   <= 4'h0;
        end else begin
            if (idle && nxt_state == L_STOP_LOW) begin
                ab_pend_ff  <= 1'b0;
                is_abort_ff <= 1'b1;
            end else if (ab_evt) begin
                ab_pend_ff  <= 1'b1;
            end
            if (idle && nxt_state == L_RC_LOW) begin
                rc_pend_ff  <= rc_pend_ff && rc_evt;
                rec_busy_ff <= 1'b1;
                rec_ok_ff   <= 1'b0;
                rec_fail_ff <= 1'b0;
                pulses_ff   <= 4'h0;
            end else if (rc_evt) begin
                rc_pend_ff  <= 1'b1;
            end
            if (state_ff == L_RC_LOW && tick) begin
                pulses_ff <= pulses_ff + 4'h1;  // [RULE_14]
            end
            if (state_ff == L_RC_HIGH && tick && !sda_f && last_rc) begin
                rec_busy_ff <= 1'b0;
                rec_fail_ff <= 1'b1;            // [RULE_20]
            end
            if (state_ff == L_STOP_REL && tick) begin
                is_abort_ff <= 1'b0;
                done_tgl_ff <= done_tgl_ff ^ is_abort_ff;   // [RULE_04]
                if (!is_abort_ff) begin
                    rec_busy_ff <= 1'b0;
                    rec_ok_ff   <= 1'b1;        // [RULE_20]
                end
            end
        end
    end

    // Pads pull low only; the data value is always zero
    always_ff @(posedge LINK_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SCL_OUT  <= 1'b0;
            SDA_OUT  <= 1'b0;
            SCL_FILT <= 1'b1;
            SDA_FILT <= 1'b1;
        end else begin
            SCL_OUT  <= 1'b0;
            SDA_OUT  <= 1'b0;
            SCL_FILT <= scl_f;
            SDA_FILT <= sda_f;
        end
    end

    assign SCL_OE = scl_oe_ff;
    assign SDA_OE = sda_oe_ff;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence done_seen_s;
        done_s2_ff != done_s3_ff;
    endsequence
    sequence flush_pair_s;
        TX_FLUSH && ABORT_DONE && ABORT_CAUSE_USER;
    endsequence

    abort_master_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE_02]
        (ABORT_REQ && !MASTER_MODE) |=> $stable(abort_tgl_ff))
        else $error("abort taken outside master mode");
    abort_issue_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE_01]
        (ABORT_REQ && MASTER_MODE) |=> !$stable(abort_tgl_ff))
        else $error("master abort request not forwarded");
    abort_report_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE_04]
        done_seen_s |=> flush_pair_s ##1 !TX_FLUSH)
        else $error("abort completion not flushed or reported");
    spk_min_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE_10]
        (SPKLEN_WR && !ENABLE && SPKLEN_WDATA == '0) |=> SPKLEN_RDATA == SPK_MIN)
        else $error("zero spike limit not raised to one");
    spk_locked_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RULE_09]
        ENABLE |=> $stable(SPKLEN_RDATA))
        else $error("spike limit changed while enabled");
    stop_order_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) // [RULE_01]
        (state_ff == L_STOP_HIGH) |-> (sda_oe_ff && !scl_oe_ff))
        else $error("STOP not formed with SCL high and SDA low");
    pulse_cap_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) // [RULE_14]
        (state_ff == L_RC_LOW) |-> (pulses_ff < RECOVER_PULSES))
        else $error("more than nine recovery pulses");
    rec_stop_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) // [RULE_16]
        (state_ff == L_RC_HIGH && tick && sda_f) |=> (state_ff == L_STOP_LOW) && sda_oe_ff)
        else $error("recovered bus not closed with STOP");
    rec_fail_a: assert property (@(posedge LINK_CLK) disable iff (!RESET_N) // [RULE_20]
        (state_ff == L_RC_HIGH && tick && !sda_f && last_rc)
            |=> (rec_fail_ff && !rec_busy_ff && state_ff == L_IDLE))
        else $error("failed recovery not reported");
endmodule

// >>> i2c_abort_clear_tb.sv
// Self-checking bench for the abort, spike filter and bus clear block.
// Assumes the package constants and an open-drain target model.
`timescale 1ns/1ps

module i2c_abort_clear_tb;
    import i2c_ctl_pkg::*;
    logic       clk, link_clk, reset_n, enable, master_mode, abort_req, cause_clr;
    logic       spk_wr, recover_req, scl_pull, sda_pull, clr, scl, sda;
    logic [7:0] spk_wdata, spk_rdata;
    logic [3:0] stuck;
    logic       abort_done, abort_cause, tx_flush, rec_busy, rec_ok, rec_fail;
    logic       scl_filt, sda_filt, scl_out, scl_oe, sda_out, sda_oe;
    int         failures, checks, cycles, scl_rises, sda_rises, done_seen;
    time        t_stop, t_done;

    i2c_abort_clear dut (.CLK(clk), .RESET_N(reset_n), .LINK_CLK(link_clk),
        .ENABLE(enable), .MASTER_MODE(master_mode), .ABORT_REQ(abort_req),
        .ABORT_CAUSE_CLR(cause_clr), .SPKLEN_WR(spk_wr), .SPKLEN_WDATA(spk_wdata),
        .RECOVER_REQ(recover_req), .SCL_IN(scl), .SDA_IN(sda),
        .SPKLEN_RDATA(spk_rdata), .ABORT_DONE(abort_done),
        .ABORT_CAUSE_USER(abort_cause), .TX_FLUSH(tx_flush),
        .RECOVER_BUSY(rec_busy), .RECOVER_OK(rec_ok), .RECOVER_FAIL(rec_fail),
        .SCL_FILT(scl_filt), .SDA_FILT(sda_filt), .SCL_OUT(scl_out),
        .SCL_OE(scl_oe), .SDA_OUT(sda_out), .SDA_OE(sda_oe));

    i2c_target_model target (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_pull(scl_pull),
        .sda_pull(sda_pull), .clr(clr), .stuck(stuck), .scl(scl), .sda(sda));

    // ------------------------------------------------------------------------
    // Clocks, monitors and hang guard
    // ------------------------------------------------------------------------
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    initial begin
        link_clk = 0;
        #7;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge scl_oe) scl_rises++;
    always @(posedge sda_oe) sda_rises++;
    // A STOP must release SDA while SCL is already released
    always @(negedge sda_oe) begin
        if (reset_n === 1'b1) begin
            check1("stop_scl_high", 1'b0, scl_oe);
            t_stop = $time;
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (abort_done === 1'b1) begin
            done_seen++;
            t_done = $time;
            check1("flush_with_done", 1'b1, tx_flush);
        end
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic check1(input string name, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, e, g);
        end
    endtask
    task automatic check8(input string name, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, e, g);
        end
    endtask
    // Inputs move 1 ns after the clock edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Writes spaced well over four link cycles apart
    task automatic wr_spk(input logic [7:0] v);
        spk_wr = 1;
        spk_wdata = v;
        step(1);
        spk_wr = 0;
        step(20);
    endtask
    // Drive one line to lvl and count link edges until the filter follows
    task automatic filt_delay(input logic on_scl, input logic lvl, input int lim);
        int n = 0;
        if (on_scl) scl_pull = !lvl;
        else sda_pull = !lvl;
        while (((on_scl ? scl_filt : sda_filt) !== lvl) && n < 40) begin
            @(posedge link_clk);
            #1;
            n++;
        end
        check1("filt_delay_min", 1'b1, n >= lim + 2);
        check1("filt_delay_max", 1'b1, n <= lim + 4);
        check1("other_line", 1'b1, on_scl ? sda_filt : scl_filt);
    endtask
    task automatic recover(input logic [3:0] k, input int exp, input logic ok);
        int n = 0;
        clr = 1;
        step(1);
        clr = 0;
        stuck = k;
        step(80);
        scl_rises = 0;
        sda_rises = 0;
        recover_req = 1;
        step(1);
        recover_req = 0;
        step(80);
        check1("rec_busy", 1'b1, rec_busy);
        check1("pad_value", 1'b0, scl_out | sda_out);
        while (rec_busy === 1'b1 && n < 8000) begin
            step(1);
            n++;
        end
        step(5);
        check1("rec_ok", ok, rec_ok);
        check1("rec_fail", !ok, rec_fail);
        check1("rec_pulses", 1'b1, scl_rises == exp);
        check1("rec_stop", ok, sda_rises == 1);
        stuck = 0;
        step(40);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {reset_n, enable, master_mode, abort_req, cause_clr, spk_wr} = '0;
        {recover_req, scl_pull, sda_pull, stuck, spk_wdata} = '0;
        clr = 1;
        step(10);
        reset_n = 1;
        step(1);
        check8("spk_reset", 8'h05, spk_rdata);
        check1("filt_reset", 1'b1, scl_filt & sda_filt);
        clr = 0;
        wr_spk(8'h00);
        check8("spk_zero", 8'h01, spk_rdata);
        enable = 1;
        wr_spk(8'h20);
        check8("spk_locked", 8'h01, spk_rdata);
        enable = 0;
        wr_spk(8'h08);
        check8("spk_set", 8'h08, spk_rdata);
        for (int i = 0; i < 4; i++) begin
            filt_delay(i[1], i[0], 8);
            step(20);
        end
        // Short pulses on each line never reach the filtered copy
        for (int i = 0; i < 2; i++) begin
            if (i == 0) scl_pull = 1;
            else sda_pull = 1;
            step(20);
            {scl_pull, sda_pull} = '0;
            repeat (30) begin
                @(posedge link_clk);
                #1;
                check1("spike_removed", 1'b1, scl_filt & sda_filt);
            end
        end
        step(1);
        abort_req = 1;
        step(1);
        abort_req = 0;
        step(1000);
        check1("target_abort", 1'b0, done_seen != 0 || scl_rises != 0);
        master_mode = 1; // No commands queued and DMA off before the abort
        sda_rises = 0;
        abort_req = 1;
        step(1);
        abort_req = 0;
        for (int n = 0; n < 2000 && done_seen == 0; n++) step(1);
        step(2);
        check1("abort_done", 1'b1, done_seen == 1);
        check1("stop_first", 1'b1, sda_rises == 1 && t_stop < t_done);
        check1("cause_user", 1'b1, abort_cause);
        cause_clr = 1;
        step(1);
        cause_clr = 0;
        step(2);
        check1("cause_clear", 1'b0, abort_cause);
        recover(4'h4, 5, 1'b1);
        recover(4'hF, 9, 1'b0);
        end_of_test();
    end
endmodule

// >>> i2c_glitch_filter.sv
// Shared constants for the abort / spike filter / bus clear block, and the
// per-line input filter (two-flop synchroniser followed by a spike counter).
// Assumes the filter runs on the link clock that also times the bus logic.

`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package i2c_ctl_pkg;
    localparam int         SPK_W          = 8;
    localparam logic [7:0] SPK_RESET      = 8'h05;   // Power-up spike limit
    localparam logic [7:0] SPK_MIN        = 8'h01;   // Smallest storable limit
    localparam int         LINK_PERIOD_NS = 80;      // Link clock period
    localparam int         HALF_NS        = 5000;    // Recovery SCL half period
    localparam int         HALF_CYC       = (HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    localparam int         HC_W           = 8;
    localparam logic [3:0] RECOVER_PULSES = 4'h9;    // Most clock pulses in a bus clear
    localparam int         SYNC_STAGES    = 2;

    typedef enum {
        L_IDLE,
        L_STOP_LOW,
        L_STOP_HIGH,
        L_STOP_REL,
        L_RC_LOW,
        L_RC_HIGH
    } link_state_t;
endpackage

// ----------------------------------------------------------------------------
// One line filter: synchroniser, then stability counter
// ----------------------------------------------------------------------------
module i2c_glitch_filter #(
    parameter int LIMIT_W = i2c_ctl_pkg::SPK_W
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic               line_in,
    input  wire logic [LIMIT_W-1:0] limit,
    output logic                    filt_out
);
    import i2c_ctl_pkg::*;

    // A zero-width limit leaves no counter to compare against
    if (LIMIT_W < 1) begin : g_bad_width
        $error("LIMIT_W must be at least 1");
    end

    logic               s1_ff;
    logic               s2_ff;
    logic               filt_ff;
    logic [LIMIT_W-1:0] cnt_ff;
    logic [LIMIT_W-1:0] nxt_cnt;
    logic               nxt_filt;
    wire                differs  = s2_ff != filt_ff;
    wire  [LIMIT_W:0]   cnt_inc  = {1'b0, cnt_ff} + {{LIMIT_W{1'b0}}, 1'b1};
    wire                at_limit = cnt_inc >= {1'b0, limit};

    // Synchroniser, independent of the spike limit; s1 feeds s2 only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff <= 1'b1;
            s2_ff <= 1'b1;
        end else begin
            s1_ff <= line_in;   // [RULE_08]
            s2_ff <= s1_ff;     // [RULE_08]
        end
    end

    // Same treatment for both edge directions; a return to the held value
    // resets and stops the count, so a spike never reaches the output
    assign nxt_cnt  = !differs ? '0 : (at_limit ? '0 : cnt_inc[LIMIT_W-1:0]); // [RULE_06] [RULE_07] [RULE_11]
    assign nxt_filt = (differs && at_limit) ? s2_ff : filt_ff;               // [RULE_06] [RULE_11]

    // Counter and filtered copy
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= '0;
            filt_ff <= 1'b1;
        end else begin
            cnt_ff  <= nxt_cnt;
            filt_ff <= nxt_filt;
        end
    end

    assign filt_out = filt_ff;

    sequence held_s;
        s2_ff == filt_ff;
    endsequence

    filt_stable_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_07]
        held_s |=> (cnt_ff == '0) && $stable(filt_ff))
        else $error("filter moved without a pending change");
    filt_update_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
        (filt_ff != $past(filt_ff)) |-> ($past(cnt_ff) + 1 >= $past(limit)))
        else $error("filter updated before reaching the limit");
endmodule

// >>> i2c_target_model.sv
// Behavioural I2C target on an open-drain SCL/SDA pair with pull-ups.
// Assumes the bench sets how many bus clock pulses SDA stays stuck low.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Target model
// ----------------------------------------------------------------------------
module i2c_target_model (
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic       scl_pull,
    input  wire logic       sda_pull,
    input  wire logic       clr,
    input  wire logic [3:0] stuck,
    output logic            scl,
    output logic            sda
);
    int seen;

    // One bit shifted out per bus clock rise; clr restarts the count
    always @(posedge scl or posedge clr) begin
        if (clr) begin
            seen <= 0;
        end else begin
            seen <= seen + 1;
        end
    end

    // Pull-ups: a released line reads high, never the last value
    assign scl = !(scl_oe || scl_pull);
    assign sda = !(sda_oe || sda_pull || (seen < stuck));
endmodule
